/* rtl/strap_cfg_pkg.sv */
package strap_cfg_pkg;

  localparam int CHANNELS = 4;
  localparam int SYM_W = 3;
  localparam int REG_W = 16;
  localparam int ADDR_W = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CONFIG_ONE = 6'h09;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 6'h12;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 6'h13;
  localparam logic [ADDR_W-1:0] OFS_CONFIG_FOUR = 6'h31;

  // Field positions
  localparam int TEST_LSB = 13;
  localparam int TEST_W = 3;
  localparam int MIRROR_BIT = 0;
  localparam int SGMII_BIT = 1;
  localparam int ADVSEL_BIT = 2;
  localparam int ANEG_DIS_BIT = 7;
  localparam int TXSKEW_LSB = 8;
  localparam int RXSKEW_LSB = 12;

  // Reset values
  localparam logic [REG_W-1:0] CONFIG_ONE_RESET = 16'h0000;
  localparam logic [REG_W-1:0] INT_MASK_RESET = 16'h0000;
  localparam logic [REG_W-1:0] INT_STATUS_RESET = 16'h0000;

  // Strap level codes: level one is 00 up to level four 11
  localparam logic [1:0] LEVEL_THREE = 2'h2;
  localparam logic [1:0] LEVEL_FOUR = 2'h3;

  // Test modes
  localparam logic [TEST_W-1:0] TEST_NORMAL = 3'h0;
  localparam logic [TEST_W-1:0] TEST_MODE_FOUR = 3'h4;
  localparam logic [SYM_W-1:0] SYM_POS2 = 3'h2;
  localparam logic [SYM_W-1:0] SYM_NEG2 = 3'h6;
  localparam logic [2:0] PATTERN_LAST = 3'h4;

  // Timing: test clock at the gigabit symbol rate
  localparam int CLK_PERIOD_NS = 4;
  localparam int TEST_CLK_PERIOD_NS = 8;
  localparam int TEST_HALF_CYCLES = TEST_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = 4;

  typedef struct packed {
    logic [1:0] indicatorZero;
    logic [1:0] indicatorOne;
    logic [1:0] indicatorTwo;
    logic [1:0] gpioOne;
    logic [1:0] gpioZero;
    logic [1:0] rxCtrl;
    logic [1:0] rxDataLane2;
    logic [1:0] rxDataLane0;
  } strap_levels_t;

  typedef struct packed {
    logic [3:0] mgmtAddr;
    logic mirrorEnable;
    logic sgmiiEnable;
    logic advertiseSelect;
    logic anegDisable;
    logic [2:0] txSkew;
    logic [2:0] rxSkew;
    logic [2:0] ledActiveLow;
  } strap_cfg_t;

  typedef enum logic [1:0] {
    PH_LATCH = 2'b00,
    PH_LOAD = 2'b01,
    PH_RUN = 2'b10
  } phase_t;

  typedef struct packed {
    phase_t phase;
    strap_levels_t latched;
    logic [REG_W-1:0] configOne;
    logic [REG_W-1:0] intMask;
    logic [REG_W-1:0] intStatus;
    logic [REG_W-1:0] configFour;
    logic [REG_W-1:0] statusPrev;
    logic [REG_W-1:0] rdData;
    logic rdValid;
    logic testClk;
    logic [DIV_W-1:0] divCount;
    logic [2:0] patCount;
    logic [CHANNELS*SYM_W-1:0] media;
    logic [2:0] indicator;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage

/* rtl/strap_decode.sv */
`timescale 1ns/100ps
module strap_decode (
  input wire strap_cfg_pkg::strap_levels_t levels, // latched strap levels
  output strap_cfg_pkg::strap_cfg_t cfg // decoded settings
);

  always_comb begin
    cfg = '0;
    cfg.mgmtAddr = {levels.rxDataLane2, levels.rxDataLane0};
    cfg.mirrorEnable = levels.indicatorZero[1];
    cfg.sgmiiEnable = levels.indicatorZero[0];
    cfg.advertiseSelect = levels.indicatorOne[1];
    cfg.txSkew = {levels.indicatorOne[0], levels.indicatorTwo};
    // Only level three is a valid high code; level four reads as zero
    cfg.rxSkew = {levels.gpioOne, levels.gpioZero == strap_cfg_pkg::LEVEL_THREE};
    // Levels one and two are not allowed on this strap and read as enabled-off
    cfg.anegDisable = levels.rxCtrl == strap_cfg_pkg::LEVEL_FOUR;
    cfg.ledActiveLow = {levels.indicatorTwo == strap_cfg_pkg::LEVEL_FOUR,
                        levels.indicatorOne == strap_cfg_pkg::LEVEL_FOUR,
                        levels.indicatorZero == strap_cfg_pkg::LEVEL_FOUR};
  end

endmodule // strap_decode

/* rtl/mirror_map.sv */
`timescale 1ns/100ps
module mirror_map #(
  parameter int SYM_W = strap_cfg_pkg::SYM_W
) (
  input wire logic [strap_cfg_pkg::CHANNELS*SYM_W-1:0] chIn, // logical channels A..D
  input wire logic mirrorOn, // mirror mode
  input wire logic gigabit, // gigabit operation
  output logic [strap_cfg_pkg::CHANNELS*SYM_W-1:0] chOut // physical channels A..D
);

  localparam int CH = strap_cfg_pkg::CHANNELS;

  for (genvar i = 0; i < CH; i++) begin : g_ch
    logic [SYM_W-1:0] own;
    logic [SYM_W-1:0] swapped;
    logic [SYM_W-1:0] fastSym;
    assign own = chIn[i*SYM_W +: SYM_W];
    // Polarity is reversed on every remapped channel
    assign swapped = SYM_W'(-chIn[(CH-1-i)*SYM_W +: SYM_W]);
    // At 10/100 only A and B carry data; they land on D and C
    assign fastSym = (i >= CH / 2) ? swapped : '0;
    assign chOut[i*SYM_W +: SYM_W] = !mirrorOn ? own : (gigabit ? swapped : fastSym);
  end

endmodule // mirror_map

/* rtl/strap_config_and_port_mirror.sv */
`timescale 1ns/100ps
// How it works
// - Sample straps at power-up and hardware reset
// - Software reset reloads captured straps, no resampling
// - Host registers override every config four strap mode; address and indicator polarity stay strapped
// - Fast mirror: A to D, B to C
// - Gigabit mirror swaps all four channels
// - Mirror enabled by strap or register bit
// - Mirroring inverts polarity of remapped channels
// - Interrupt output on selected status changes
// - Mask register selects; status register reports pending
// - Test mode field selects four modes
// - Test mode drives pattern and synchronous clock
// - Advertise select picks 100/1000 or 10/100/1000
// - Hardware reset relatches; software reset keeps straps
// - Indicator polarity low only for level four
// - Unstrapped address pins resolve to zero
module strap_config_and_port_mirror #(
  parameter int TEST_HALF_CYCLES = strap_cfg_pkg::TEST_HALF_CYCLES
) (
  input wire logic clock, // 250 MHz core clock
  input wire logic rst_n, // power-up or hardware reset, sync, active low
  input wire strap_cfg_pkg::strap_levels_t strapPins, // resolved strap levels
  input wire logic softReset, // global software reset pulse
  input wire logic linkGigabit, // link runs at 1000 Mb/s
  input wire logic [strap_cfg_pkg::CHANNELS*strap_cfg_pkg::SYM_W-1:0] txSymbols, // PCS symbols
  output logic [strap_cfg_pkg::CHANNELS*strap_cfg_pkg::SYM_W-1:0] mediaSymbols, // to MDI
  output logic [3:0] mgmtAddr, // management address
  output logic sgmiiEnable, // SGMII MAC interface
  output logic anegDisable, // auto-negotiation disabled
  output logic [2:0] txSkew, // transmit clock skew code
  output logic [2:0] rxSkew, // receive clock skew code
  output logic [2:0] advertise, // abilities {1000,100,10}
  input wire logic [2:0] ledDrive, // indicator functions, active high
  output logic [2:0] indicatorOut, // indicator pin levels
  output logic [2:0] indicatorOe, // indicator pin enables
  input wire logic [strap_cfg_pkg::REG_W-1:0] statusIn, // internal status conditions
  output logic irq, // interrupt to the MAC, active high
  input wire logic regWrEn, // management register write
  input wire logic regRdEn, // management register read
  input wire logic [strap_cfg_pkg::ADDR_W-1:0] regAddr, // register offset
  input wire logic [strap_cfg_pkg::REG_W-1:0] regWrData, // write data
  output logic [strap_cfg_pkg::REG_W-1:0] regRdData, // read data
  output logic regRdValid, // read data valid pulse
  output logic testModeActive, // a test mode is selected
  output logic testClockOut // clock synchronous to test pattern
);

  localparam int SW = strap_cfg_pkg::SYM_W;
  localparam int CH = strap_cfg_pkg::CHANNELS;

  if (TEST_HALF_CYCLES < 1 || TEST_HALF_CYCLES >= (1 << strap_cfg_pkg::DIV_W)) begin : g_chk
    $error("TEST_HALF_CYCLES out of range");
  end

  strap_cfg_pkg::state_t s_reg;
  strap_cfg_pkg::state_t s_next;
  strap_cfg_pkg::strap_cfg_t decoded;
  logic [strap_cfg_pkg::REG_W-1:0] strapConfigFour;
  logic [strap_cfg_pkg::REG_W-1:0] changed;
  logic [strap_cfg_pkg::REG_W-1:0] readClear;
  logic [strap_cfg_pkg::TEST_W-1:0] testMode;
  logic testActive;
  logic tick;
  logic [SW-1:0] patSym;
  logic [CH*SW-1:0] sourceSymbols;
  logic [CH*SW-1:0] mirrored;
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and datapath

  strap_decode u_decode (
    .levels(s_reg.latched),
    .cfg(decoded)
  );

  always_comb begin
    strapConfigFour = '0;
    strapConfigFour[strap_cfg_pkg::MIRROR_BIT] = decoded.mirrorEnable;
    strapConfigFour[strap_cfg_pkg::SGMII_BIT] = decoded.sgmiiEnable;
    strapConfigFour[strap_cfg_pkg::ADVSEL_BIT] = decoded.advertiseSelect;
    strapConfigFour[strap_cfg_pkg::ANEG_DIS_BIT] = decoded.anegDisable;
    strapConfigFour[strap_cfg_pkg::TXSKEW_LSB +: 3] = decoded.txSkew;
    strapConfigFour[strap_cfg_pkg::RXSKEW_LSB +: 3] = decoded.rxSkew;
  end

  assign running = s_reg.phase == strap_cfg_pkg::PH_RUN;
  assign testMode = s_reg.configOne[strap_cfg_pkg::TEST_LSB +: strap_cfg_pkg::TEST_W];
  // Codes above four are reserved and leave the transmitter in normal use
  assign testActive = testMode != strap_cfg_pkg::TEST_NORMAL
                      && testMode <= strap_cfg_pkg::TEST_MODE_FOUR;
  assign tick = s_reg.divCount == strap_cfg_pkg::DIV_W'(TEST_HALF_CYCLES - 1);

  // Mode four steps through all five levels; others toggle full swing
  always_comb begin
    if (testMode == strap_cfg_pkg::TEST_MODE_FOUR) begin
      patSym = SW'(s_reg.patCount) + strap_cfg_pkg::SYM_NEG2;
    end else begin
      patSym = s_reg.testClk ? strap_cfg_pkg::SYM_POS2 : strap_cfg_pkg::SYM_NEG2;
    end
  end

  assign sourceSymbols = testActive ? {CH{patSym}} : txSymbols;

  mirror_map #(
    .SYM_W(SW)
  ) u_mirror (
    .chIn(sourceSymbols),
    .mirrorOn(s_reg.configFour[strap_cfg_pkg::MIRROR_BIT]),
    .gigabit(linkGigabit),
    .chOut(mirrored)
  );

  assign changed = statusIn ^ s_reg.statusPrev;
  assign readClear = (regRdEn && regAddr == strap_cfg_pkg::OFS_INT_STATUS) ? s_reg.intStatus : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    s_next.rdValid = 1'b0;
    s_next.media = mirrored;
    s_next.indicator = ledDrive ^ decoded.ledActiveLow;
    if (testActive) begin
      s_next.divCount = tick ? '0 : s_reg.divCount + 1'b1;
      if (tick) begin
        s_next.testClk = ~s_reg.testClk;
        if (!s_reg.testClk) begin
          s_next.patCount = (s_reg.patCount == strap_cfg_pkg::PATTERN_LAST)
                            ? '0 : s_reg.patCount + 1'b1;
        end
      end
    end else begin
      s_next.divCount = '0;
      s_next.testClk = 1'b0;
      s_next.patCount = '0;
    end
    case (s_reg.phase)
      strap_cfg_pkg::PH_LATCH: begin
        // Pins are sampled only here, one edge after reset release
        s_next.latched = strapPins;
        s_next.phase = strap_cfg_pkg::PH_LOAD;
      end
      strap_cfg_pkg::PH_LOAD: begin
        s_next.configOne = strap_cfg_pkg::CONFIG_ONE_RESET;
        s_next.intMask = strap_cfg_pkg::INT_MASK_RESET;
        s_next.intStatus = strap_cfg_pkg::INT_STATUS_RESET;
        s_next.configFour = strapConfigFour;
        s_next.statusPrev = statusIn;
        s_next.phase = strap_cfg_pkg::PH_RUN;
      end
      strap_cfg_pkg::PH_RUN: begin
        s_next.statusPrev = statusIn;
        if (softReset) begin
          s_next.phase = strap_cfg_pkg::PH_LOAD;
        end else begin
          // A change in the same cycle as the clearing read stays pending
          s_next.intStatus = (s_reg.intStatus & ~readClear) | changed;
          if (regRdEn) begin
            s_next.rdValid = 1'b1;
            case (regAddr)
              strap_cfg_pkg::OFS_CONFIG_ONE: s_next.rdData = s_reg.configOne;
              strap_cfg_pkg::OFS_INT_MASK: s_next.rdData = s_reg.intMask;
              strap_cfg_pkg::OFS_INT_STATUS: s_next.rdData = s_reg.intStatus;
              strap_cfg_pkg::OFS_CONFIG_FOUR: s_next.rdData = s_reg.configFour;
              default: s_next.rdData = '0;
            endcase
          end
          if (regWrEn) begin
            case (regAddr)
              strap_cfg_pkg::OFS_CONFIG_ONE: s_next.configOne = regWrData;
              strap_cfg_pkg::OFS_INT_MASK: s_next.intMask = regWrData;
              strap_cfg_pkg::OFS_CONFIG_FOUR: s_next.configFour = regWrData;
              default: s_next.configFour = s_next.configFour;
            endcase
          end
        end
      end
      default: s_next.phase = strap_cfg_pkg::PH_LATCH;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg <= strap_cfg_pkg::STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign mediaSymbols = s_reg.media;
  assign mgmtAddr = decoded.mgmtAddr;
  assign sgmiiEnable = s_reg.configFour[strap_cfg_pkg::SGMII_BIT];
  assign anegDisable = s_reg.configFour[strap_cfg_pkg::ANEG_DIS_BIT];
  assign txSkew = s_reg.configFour[strap_cfg_pkg::TXSKEW_LSB +: 3];
  assign rxSkew = s_reg.configFour[strap_cfg_pkg::RXSKEW_LSB +: 3];
  assign advertise = {2'h3, !s_reg.configFour[strap_cfg_pkg::ADVSEL_BIT]};
  assign indicatorOut = s_reg.indicator;
  // Pins stay released while straps are being read
  assign indicatorOe = {3{running}};
  assign irq = |(s_reg.intStatus & s_reg.intMask);
  assign regRdData = s_reg.rdData;
  assign regRdValid = s_reg.rdValid;
  assign testModeActive = testActive;
  assign testClockOut = s_reg.testClk;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence softResetSeq;
    running && softReset;
  endsequence

  sequence reloadSeq;
    s_reg.phase == strap_cfg_pkg::PH_LOAD
    ##1 (running && s_reg.configFour == strapConfigFour);
  endsequence

  AST_LATCH_STRAPS: assert property (
    s_reg.phase == strap_cfg_pkg::PH_LATCH |=> s_reg.latched == $past(strapPins)
  ) else $error("strap levels not captured after reset");

  AST_SOFT_RELOAD: assert property (
    softResetSeq |=> $stable(s_reg.latched) ##0 reloadSeq
  ) else $error("software reset did not reload captured straps");

  AST_HOST_OVERRIDE: assert property (
    running && !softReset && regWrEn && regAddr == strap_cfg_pkg::OFS_CONFIG_FOUR
    |=> s_reg.configFour == $past(regWrData)
  ) else $error("host write to config four not applied");

  AST_ADDR_ZERO: assert property (
    s_reg.phase == strap_cfg_pkg::PH_LOAD && s_reg.latched == '0 |-> mgmtAddr == 4'h0
  ) else $error("unstrapped address not zero");

  AST_MIRROR_GIG: assert property (
    s_reg.configFour[strap_cfg_pkg::MIRROR_BIT] && linkGigabit && !testActive
    |=> SW'(mediaSymbols[0 +: SW] + $past(txSymbols[3*SW +: SW])) == '0
  ) else $error("gigabit mirror D to A with inversion failed");

  AST_MIRROR_FAST: assert property (
    s_reg.configFour[strap_cfg_pkg::MIRROR_BIT] && !linkGigabit && !testActive
    |=> SW'(mediaSymbols[3*SW +: SW] + $past(txSymbols[0 +: SW])) == '0
  ) else $error("fast mirror A to D with inversion failed");

  AST_INT_CAPTURE: assert property (
    running && !softReset && changed != '0
    |=> (s_reg.intStatus & $past(changed)) == $past(changed)
  ) else $error("status change not held pending");

  AST_INT_MASKED: assert property (
    (s_reg.intStatus & s_reg.intMask) == '0 |-> !irq
  ) else $error("interrupt raised with no unmasked source");

  AST_TEST_CLOCK: assert property (
    testActive && tick |=> testClockOut != $past(testClockOut)
  ) else $error("test clock did not toggle on divider tick");

  AST_ADVERTISE: assert property (
    running && s_reg.configFour[strap_cfg_pkg::ADVSEL_BIT] |-> advertise == 3'h6
  ) else $error("advertise select did not drop 10 Mb/s");

  AST_LED_POLARITY: assert property (
    running |=> indicatorOut == $past(ledDrive ^ decoded.ledActiveLow)
  ) else $error("indicator polarity does not follow strap level");

  // Register defaults after either reset; straps survive only in config four
  sequence defaultsSeq;
    s_reg.configOne == strap_cfg_pkg::CONFIG_ONE_RESET
    && s_reg.intMask == strap_cfg_pkg::INT_MASK_RESET
    && s_reg.intStatus == strap_cfg_pkg::INT_STATUS_RESET;
  endsequence

  AST_LOAD_DEFAULTS: assert property (
    s_reg.phase == strap_cfg_pkg::PH_LOAD |=> defaultsSeq
  ) else $error("registers not back at defaults after reset");

  // A host write to the mask in the same cycle may legally hide the source
  AST_IRQ_UNMASKED: assert property (
    running && !softReset && (changed & s_reg.intMask) != '0
    && !(regWrEn && regAddr == strap_cfg_pkg::OFS_INT_MASK) |=> irq
  ) else $error("unmasked status change raised no interrupt");

  AST_TEST_IDLE: assert property (
    !testActive |=> !testClockOut
  ) else $error("test clock running outside a test mode");

  AST_READ_VALID: assert property (
    running && !softReset && regRdEn |=> regRdValid
  ) else $error("register read not answered in the next cycle");

endmodule // strap_config_and_port_mirror

/* verif/strap_board.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module strap_board (
  input wire strap_cfg_pkg::strap_levels_t fitted, // resistor levels on the board
  input wire logic populated, // strap resistors present
  output strap_cfg_pkg::strap_levels_t strapPins // levels seen by the device
);
  always_comb begin
    // Bare pins fall to level one through the internal pull-downs
    strapPins = populated ? fitted : '0;
    // The skew-bit-0 pin is only ever fitted for level one or three
    strapPins.gpioZero[0] = 1'b0;
  end
endmodule // strap_board

/* verif/strap_config_and_port_mirror_bench.sv */
`timescale 1ns/100ps
module strap_config_and_port_mirror_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic softReset = 1'b0;
  logic linkGigabit = 1'b1;
  logic [11:0] txSymbols = 12'hED1;
  logic [2:0] ledDrive = 3'h5;
  logic [15:0] statusIn = 16'h0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000;
  strap_cfg_pkg::strap_levels_t fitted = '0;
  logic populated = 1'b0;
  strap_cfg_pkg::strap_levels_t strapPins;
  logic [11:0] mediaSymbols;
  logic [3:0] mgmtAddr;
  logic sgmiiEnable, anegDisable, irq, regRdValid, testModeActive, testClockOut;
  logic [2:0] txSkew, rxSkew, advertise, indicatorOut, indicatorOe;
  logic [15:0] regRdData;
  logic [15:0] d;
  logic tc;
  int errCount = 0;
  int samplesChecked = 0;

  always #2 clock = ~clock;

  strap_board u_board (.fitted(fitted), .populated(populated), .strapPins(strapPins));

  strap_config_and_port_mirror u_dut (
    .clock(clock), .rst_n(rst_n), .strapPins(strapPins), .softReset(softReset),
    .linkGigabit(linkGigabit), .txSymbols(txSymbols), .mediaSymbols(mediaSymbols),
    .mgmtAddr(mgmtAddr), .sgmiiEnable(sgmiiEnable), .anegDisable(anegDisable),
    .txSkew(txSkew), .rxSkew(rxSkew), .advertise(advertise), .ledDrive(ledDrive),
    .indicatorOut(indicatorOut), .indicatorOe(indicatorOe), .statusIn(statusIn),
    .irq(irq), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .testModeActive(testModeActive), .testClockOut(testClockOut)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected mirror output; 10/100 leaves physical A and B idle
  function automatic logic [11:0] mirExp(input logic [11:0] s, input logic g);
    logic [11:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      if (g || i >= 2) r[i*3 +: 3] = 3'h0 - s[(3-i)*3 +: 3];
    end
    return r;
  endfunction

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clock);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clock);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRdEn <= 1'b0;
    // Valid stands only in the cycle after the taking edge
    #1;
    chk("regRdValid", regRdValid, 1);
    v = regRdData;
  endtask

  task automatic hwReset(input strap_cfg_pkg::strap_levels_t f, input logic p);
    @(posedge clock);
    fitted <= f;
    populated <= p;
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic stepChk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(4 * 20000);
    errCount++;
    closeOut();
  end

  initial begin
    hwReset(16'hE6B9, 1'b1);
    chk("mgmtAddr", mgmtAddr, 16'h0009);
    chk("sgmiiEnable", sgmiiEnable, 16'h0001);
    chk("anegDisable", anegDisable, 16'h0001);
    chk("txSkew", txSkew, 16'h0001);
    chk("rxSkew", rxSkew, 16'h0005);
    chk("advertise", advertise, 16'h0006);
    chk("indicatorOut", indicatorOut, 16'h0004);
    chk("indicatorOe", indicatorOe, 16'h0007);
    rd(strap_cfg_pkg::OFS_CONFIG_FOUR, d);
    chk("config four", d, 16'h5187);
    for (int g = 0; g < 2; g++) begin
      @(posedge clock);
      linkGigabit <= g[0];
      stepChk(3);
      chk("mirrored media", mediaSymbols, mirExp(txSymbols, g[0]));
    end
    // Host clears autoneg disable and overrides every config four strapped mode
    wr(strap_cfg_pkg::OFS_CONFIG_FOUR, 16'h0000);
    wr(strap_cfg_pkg::OFS_INT_MASK, 16'hFFFF);
    stepChk(2);
    chk("media unmirrored", mediaSymbols, txSymbols);
    chk("sgmii override", sgmiiEnable, 16'h0000);
    chk("advertise override", advertise, 16'h0007);
    chk("rxSkew override", rxSkew, 16'h0000);
    // Pins move after reset; a soft reset must not pick that up
    @(posedge clock);
    fitted <= '0;
    softReset <= 1'b1;
    @(posedge clock);
    softReset <= 1'b0;
    stepChk(3);
    chk("mgmtAddr kept", mgmtAddr, 16'h0009);
    rd(strap_cfg_pkg::OFS_CONFIG_FOUR, d);
    chk("config four reloaded", d, 16'h5187);
    rd(strap_cfg_pkg::OFS_INT_MASK, d);
    chk("mask defaulted", d, strap_cfg_pkg::INT_MASK_RESET);
    hwReset('0, 1'b0);
    chk("bare address", mgmtAddr, 16'h0000);
    chk("bare indicators", indicatorOut, 16'h0005);
    rd(strap_cfg_pkg::OFS_CONFIG_FOUR, d);
    chk("bare config four", d, 16'h0000);
    wr(strap_cfg_pkg::OFS_CONFIG_FOUR, 16'h0001);
    stepChk(2);
    chk("register mirror", mediaSymbols, mirExp(txSymbols, 1'b1));
    wr(strap_cfg_pkg::OFS_CONFIG_FOUR, 16'h0000);
    // Interrupts: a masked source must stay silent
    wr(strap_cfg_pkg::OFS_INT_MASK, 16'h0008);
    @(posedge clock);
    statusIn <= 16'h0010;
    stepChk(3);
    chk("irq masked out", irq, 16'h0000);
    @(posedge clock);
    statusIn <= 16'h0018;
    for (int i = 0; i < 3 && irq !== 1'b1; i++) stepChk(1);
    chk("irq raised", irq, 16'h0001);
    rd(strap_cfg_pkg::OFS_INT_STATUS, d);
    chk("status pending", d, 16'h0018);
    stepChk(1);
    chk("irq cleared", irq, 16'h0000);
    wr(strap_cfg_pkg::OFS_INT_STATUS, 16'hFFFF);
    rd(strap_cfg_pkg::OFS_INT_STATUS, d);
    chk("status not writable", d, 16'h0000);
    rd(6'h3F, d);
    chk("unmapped read", d, 16'h0000);
    // Every test mode and normal operation
    // Code five is reserved and must leave the transmitter in normal use
    for (int m = 0; m < 6; m++) begin
      wr(strap_cfg_pkg::OFS_CONFIG_ONE, 16'(m) << strap_cfg_pkg::TEST_LSB);
      rd(strap_cfg_pkg::OFS_CONFIG_ONE, d);
      chk("config one", d, 16'(m) << strap_cfg_pkg::TEST_LSB);
      chk("testModeActive", testModeActive, 16'(m != 0 && m <= 4));
      tc = testClockOut;
      stepChk(1);
      if (m == 0 || m > 4) chk("normal media", mediaSymbols, txSymbols);
      else chk("test clock toggles", testClockOut, 16'(!tc));
      if (m >= 1 && m <= 3) begin
        chk("pattern symbol", 16'(mediaSymbols[2:0] == strap_cfg_pkg::SYM_POS2 ||
          mediaSymbols[2:0] == strap_cfg_pkg::SYM_NEG2), 16'h0001);
        chk("pattern all lanes", 16'(mediaSymbols == {4{mediaSymbols[2:0]}}), 16'h0001);
      end
    end
    closeOut();
  end
endmodule // strap_config_and_port_mirror_bench
